// ### logic/scss_pkg.sv
// Package for the system clock source select block: map, fields, modes, timing
package scss_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_OSC_CONTROL = 8'h00;
	localparam logic [7:0] OFS_INT_STATUS  = 8'h04;
	localparam logic [7:0] OFS_INT_MASK    = 8'h08;
	localparam logic [7:0] OFS_CLK_STATUS  = 8'h0c;

	// Oscillator control field positions
	localparam int POS_SCS  = 0;
	localparam int POS_LTS  = 1;
	localparam int POS_HTS  = 2;
	localparam int POS_STARTUP_TIMER_STATUS = 3;
	localparam int POS_IFS  = 4;

	// Reset values, and the internal_freq_select code that picks the slow oscillator
	localparam logic [2:0] IFS_RESET = 3'h6;
	localparam logic       SCS_RESET = 1'h0;
	localparam logic [2:0] IFS_SLOW  = 3'h0;

	// Interrupt event bit positions
	localparam int EV_FAIL = 0;
	localparam int EV_OST  = 1;
	localparam int EV_HTS  = 2;
	localparam int EV_W    = 3;

	// Timing: time without an external edge before the monitor declares failure
	localparam int CLK_PERIOD_NS = 10;
	localparam int FAIL_TIME_NS  = 2000;
	localparam int FAIL_CYCLES   = FAIL_TIME_NS / CLK_PERIOD_NS;
	localparam int OST_EDGES     = 1024;
	localparam int CNT_W         = 11;

	// Clock modes, in configuration-field order
	typedef enum logic [2:0] {
		ext_clock_input_mode,
		low_gain_crystal_mode,
		medium_gain_crystal_mode,
		high_gain_crystal_mode,
		resistor_capacitor_clkout_mode,
		resistor_capacitor_gpio_mode,
		internal_osc_clkout_mode,
		internal_osc_gpio_mode
	} scss_mode_e;

	// System clock source codes
	typedef enum logic [1:0] {
		SRC_EXT,
		SRC_FAST,
		SRC_SLOW
	} scss_src_e;

	// Pin drive group: output value and active-low enable
	typedef struct packed {
		logic o;
		logic oe_n;
	} scss_pin_s;

	// AHB data phase bookkeeping
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
	} scss_bus_s;

endpackage

// ### logic/scss_top.sv
// System clock source select with fail-safe monitor and AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none

// How it works
// RL1: Eight clock modes come from the three-bit clock_mode_select strap.
// RL2: External clock input mode runs from the external clock; pin a is GPIO.
// RL3: Crystal modes drive the oscillator at low, medium or high gain.
// RL4: RC clock-out mode runs from RC and drives clock/4 on pin a.
// RL5: RC GPIO mode runs from RC and leaves pin a as GPIO.
// RL6: Internal clock-out mode drives clock/4 on pin a; pin b is GPIO.
// RL7: Internal GPIO mode runs internally; pins a and b are both GPIO.
// RL8: Software picks external or internal system clock at run time.
// RL9: Two-speed start-up runs internally until the external oscillator is ready.
// RL10: Fail-safe monitor switches to internal oscillator when the external clock stops.
// RL11: Two internal oscillators: fast calibrated and slow uncalibrated.
// RL12: fast_osc_stable is read-only and reads 0 while the fast oscillator is unstable.
// RL13: slow_osc_stable reads 1 once the slow oscillator is stable.
// RL14: Reset loads internal_freq_select 110, clears system_clock_select; top bit reads 0.
// RL15: system_clock_select 1 picks internal block; 0 picks the configured mode's source.
module scss_top #(
	parameter int FAIL_CYC = scss_pkg::FAIL_CYCLES,
	parameter int OST_CNT  = scss_pkg::OST_EDGES
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Configuration straps, caught once after reset release
	input  wire logic [2:0]  clock_mode_select,
	input  wire logic        two_speed_enable,
	input  wire logic        fail_safe_enable,
	// Oscillator pins and status from the analog side
	input  wire logic        ext_clk_in,
	input  wire logic        fast_osc_ready,
	input  wire logic        slow_osc_ready,
	// Shared pins
	input  wire logic        pin_a_i,
	output logic             pin_a_o,
	output logic             pin_a_oe_n,
	input  wire logic        pin_b_i,
	output logic             pin_b_o,
	output logic             pin_b_oe_n,
	// Port logic side of the shared pins
	input  wire logic        gpio_a_out,
	input  wire logic        gpio_a_drive,
	input  wire logic        gpio_b_out,
	input  wire logic        gpio_b_drive,
	output logic             gpio_a_in,
	output logic             gpio_b_in,
	// Clock tree control and interrupt
	output scss_pkg::scss_src_e sys_clk_src,
	output logic [1:0]       xtal_gain,
	output logic [2:0]       internal_freq_select,
	output logic             irq
);

	localparam logic [scss_pkg::CNT_W-1:0] FAIL_LIM = scss_pkg::CNT_W'(FAIL_CYC);
	localparam logic [scss_pkg::CNT_W-1:0] OST_LIM  = scss_pkg::CNT_W'(OST_CNT);

	typedef struct packed {
		logic                        cfg_done;
		scss_pkg::scss_mode_e        mode;
		logic                        two_speed;
		logic                        fail_safe_clock_monitor_en;
		logic [2:0]                  ifs;
		logic                        system_clock_select;
		logic [2:0]                  ext_sync;
		logic [2:0]                  fast_sync;
		logic [1:0]                  slow_sync;
		logic [1:0]                  pa_sync;
		logic [1:0]                  pb_sync;
		logic [scss_pkg::CNT_W-1:0]  edge_cnt;
		logic [scss_pkg::CNT_W-1:0]  watch_cnt;
		logic                        ost_done;
		logic                        failed;
		logic [scss_pkg::EV_W-1:0]   istat;
		logic [scss_pkg::EV_W-1:0]   imask;
		logic [1:0]                  div;
		scss_pkg::scss_pin_s         pa;
		scss_pkg::scss_pin_s         pb;
		logic                        gpa_in;
		logic                        gpb_in;
		scss_pkg::scss_src_e         src;
		logic [1:0]                  gain;
		logic                        irq;
		scss_pkg::scss_bus_s         bus;
		logic                        hready;
		logic [31:0]                 rdata;
	} scss_state_s;

	scss_state_s s_q;
	scss_state_s s_d;

	// Modes that run from something outside the chip
	function automatic logic is_external(input scss_pkg::scss_mode_e m);
		return (m != scss_pkg::internal_osc_clkout_mode) &&
		       (m != scss_pkg::internal_osc_gpio_mode);
	endfunction

	// Crystal modes need the start-up timer; others count as ready at the first edge
	function automatic logic is_crystal(input scss_pkg::scss_mode_e m);
		return (m == scss_pkg::low_gain_crystal_mode) ||
		       (m == scss_pkg::medium_gain_crystal_mode) ||
		       (m == scss_pkg::high_gain_crystal_mode);
	endfunction

	// Oscillator control byte as software sees it
	function automatic logic [7:0] osc_ctrl_byte(input scss_state_s s);
		logic [7:0] b;
		b = 8'h00;
		b[scss_pkg::POS_IFS +: 3] = s.ifs;
		b[scss_pkg::POS_STARTUP_TIMER_STATUS]     = s.ost_done & ~s.failed & (s.src == scss_pkg::SRC_EXT);
		b[scss_pkg::POS_HTS]      = s.fast_sync[1];
		b[scss_pkg::POS_LTS]      = s.slow_sync[1];
		b[scss_pkg::POS_SCS]      = s.system_clock_select;
		return b;
	endfunction

	logic                      ext_rise;
	logic                      ext_mode;
	logic                      use_internal;
	logic                      start_internal;
	logic [scss_pkg::EV_W-1:0] ev;
	logic [scss_pkg::EV_W-1:0] w1c;
	logic [7:0]                rsel;
	logic                      hts_rise;
	logic                      ost_now;
	scss_pkg::scss_pin_s       pa_n;
	scss_pkg::scss_pin_s       pb_n;

	always_comb begin
		s_d = s_q;
		ev  = '0;
		w1c = '0;

		// Straps are caught once, on the first edge after reset release
		if (!s_q.cfg_done) begin
			s_d.cfg_done  = 1'b1;
			s_d.mode      = scss_pkg::scss_mode_e'(clock_mode_select); // RL1
			s_d.two_speed = two_speed_enable;
			s_d.fail_safe_clock_monitor_en   = fail_safe_enable;
		end

		// Pin and analog inputs pass two flops before use
		s_d.ext_sync  = {s_q.ext_sync[1:0], ext_clk_in};
		s_d.fast_sync = {s_q.fast_sync[1:0], fast_osc_ready};
		s_d.slow_sync = {s_q.slow_sync[0], slow_osc_ready};
		s_d.pa_sync   = {s_q.pa_sync[0], pin_a_i};
		s_d.pb_sync   = {s_q.pb_sync[0], pin_b_i};
		s_d.gpa_in    = s_q.pa_sync[1];
		s_d.gpb_in    = s_q.pb_sync[1];
		ext_rise      = s_q.ext_sync[1] & ~s_q.ext_sync[2];
		hts_rise      = s_q.fast_sync[1] & ~s_q.fast_sync[2]; // Third stage keeps edges off stage one
		ext_mode      = s_q.cfg_done & is_external(s_q.mode);

		// Start-up timer counts external edges; crystal needs the full count
		ost_now = 1'b0;
		if (ext_mode && !s_q.ost_done && ext_rise) begin
			s_d.edge_cnt = s_q.edge_cnt + 1'b1;
			if (!is_crystal(s_q.mode) || (s_d.edge_cnt >= OST_LIM)) begin
				s_d.ost_done = 1'b1;
				ost_now      = 1'b1;
			end
		end

		// Fail-safe monitor: a silent external clock for the limit means failure
		if (ext_rise || !ext_mode) begin
			s_d.watch_cnt = '0;
		end else if (s_q.watch_cnt != FAIL_LIM) begin
			s_d.watch_cnt = s_q.watch_cnt + 1'b1;
		end
		if (ext_mode && s_q.fail_safe_clock_monitor_en && !s_q.failed &&
		    (s_q.watch_cnt == FAIL_LIM)) begin
			s_d.failed = 1'b1; // RL10
		end

		// Source choice: software select, two-speed hand-over, fail-safe fallback
		start_internal = s_q.two_speed & is_crystal(s_q.mode) & ~s_q.ost_done; // RL9
		use_internal   = s_q.system_clock_select | ~ext_mode | s_q.failed | start_internal; // RL8 RL15 RL10
		if (!use_internal) begin
			s_d.src = scss_pkg::SRC_EXT; // RL2 RL4 RL5
		end else if (s_q.ifs == scss_pkg::IFS_SLOW) begin
			s_d.src = scss_pkg::SRC_SLOW; // RL11
		end else begin
			s_d.src = scss_pkg::SRC_FAST; // RL11
		end

		// Oscillator drive strength follows the crystal mode; zero until the straps are caught
		case (s_q.mode)
			scss_pkg::low_gain_crystal_mode:    s_d.gain = 2'h1; // RL3
			scss_pkg::medium_gain_crystal_mode: s_d.gain = 2'h2; // RL3
			scss_pkg::high_gain_crystal_mode:   s_d.gain = 2'h3; // RL3
			default:                            s_d.gain = 2'h0;
		endcase
		if (!s_q.cfg_done) begin
			s_d.gain = 2'h0;
		end

		// Quarter-rate clock output, high for two cycles of every four
		s_d.div = s_q.div + 2'h1;

		// Shared pin use per mode; oe_n high leaves the pin to the oscillator
		pa_n = '{o: gpio_a_out, oe_n: ~gpio_a_drive};
		pb_n = '{o: 1'b0, oe_n: 1'b1};
		case (s_q.mode)
			scss_pkg::ext_clock_input_mode,
			scss_pkg::resistor_capacitor_gpio_mode: begin
				pa_n = '{o: gpio_a_out, oe_n: ~gpio_a_drive}; // RL2 RL5
			end
			scss_pkg::resistor_capacitor_clkout_mode: begin
				pa_n = '{o: s_q.div[1], oe_n: 1'b0}; // RL4
			end
			scss_pkg::internal_osc_clkout_mode: begin
				pa_n = '{o: s_q.div[1], oe_n: 1'b0}; // RL6
				pb_n = '{o: gpio_b_out, oe_n: ~gpio_b_drive}; // RL6
			end
			scss_pkg::internal_osc_gpio_mode: begin
				pa_n = '{o: gpio_a_out, oe_n: ~gpio_a_drive}; // RL7
				pb_n = '{o: gpio_b_out, oe_n: ~gpio_b_drive}; // RL7
			end
			default: begin
				pa_n = '{o: 1'b0, oe_n: 1'b1};
			end
		endcase
		if (!s_q.cfg_done) begin
			pa_n = '{o: 1'b0, oe_n: 1'b1};
			pb_n = '{o: 1'b0, oe_n: 1'b1};
		end
		s_d.pa = pa_n;
		s_d.pb = pb_n;

		// Bus data phase: writes land at the end of it
		s_d.hready = 1'b1;
		if (s_q.bus.wr) begin
			case (s_q.bus.addr)
				scss_pkg::OFS_OSC_CONTROL: begin
					s_d.ifs = hwdata[scss_pkg::POS_IFS +: 3]; // RL14
					s_d.system_clock_select = hwdata[scss_pkg::POS_SCS]; // RL8
				end
				scss_pkg::OFS_INT_STATUS: w1c = hwdata[scss_pkg::EV_W-1:0];
				scss_pkg::OFS_INT_MASK:   s_d.imask = hwdata[scss_pkg::EV_W-1:0];
				default: ;
			endcase
		end

		// Reads take one wait cycle so a write just before is seen
		rsel = s_q.bus.addr;
		if (s_q.bus.rd && !s_q.hready) begin
			case (rsel)
				scss_pkg::OFS_OSC_CONTROL: s_d.rdata = {24'h0, osc_ctrl_byte(s_q)}; // RL12 RL13 RL14
				scss_pkg::OFS_INT_STATUS:  s_d.rdata = {29'h0, s_q.istat};
				scss_pkg::OFS_INT_MASK:    s_d.rdata = {29'h0, s_q.imask};
				scss_pkg::OFS_CLK_STATUS:  s_d.rdata = {24'h0, s_q.src, s_q.failed,
				                                        s_q.ost_done, 1'b0, s_q.mode};
				default:                   s_d.rdata = 32'h0;
			endcase
		end
		if (s_q.bus.rd && !s_q.hready) begin
			s_d.bus.rd = 1'b0;
		end else begin
			s_d.bus = '{wr: 1'b0, rd: 1'b0, addr: 8'h00};
		end
		if (hsel && htrans[1] && hready) begin
			s_d.bus = '{wr: hwrite, rd: ~hwrite, addr: {haddr[7:2], 2'b00}};
			if (!hwrite) begin
				s_d.hready = 1'b0;
			end
		end

		// Sticky events; a new event wins over a clear in the same cycle
		ev[scss_pkg::EV_FAIL] = s_d.failed & ~s_q.failed;
		ev[scss_pkg::EV_OST]  = ost_now;
		ev[scss_pkg::EV_HTS]  = hts_rise;
		s_d.istat = (s_q.istat & ~w1c) | ev;
		s_d.irq   = |(s_d.istat & s_d.imask);
	end

	// One register for all state; straps are never read under reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q        <= '0;
			s_q.mode   <= scss_pkg::ext_clock_input_mode;
			s_q.ifs    <= scss_pkg::IFS_RESET; // RL14
			s_q.system_clock_select    <= scss_pkg::SCS_RESET; // RL14
			s_q.pa     <= '{o: 1'b0, oe_n: 1'b1};
			s_q.pb     <= '{o: 1'b0, oe_n: 1'b1};
			s_q.src    <= scss_pkg::SRC_FAST;
			s_q.hready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Every output but hresp straight from the state register; hresp is tied to 0
	assign hrdata               = s_q.rdata;
	assign hreadyout            = s_q.hready;
	assign hresp                = 1'b0;
	assign pin_a_o              = s_q.pa.o;
	assign pin_a_oe_n           = s_q.pa.oe_n;
	assign pin_b_o              = s_q.pb.o;
	assign pin_b_oe_n           = s_q.pb.oe_n;
	assign gpio_a_in            = s_q.gpa_in;
	assign gpio_b_in            = s_q.gpb_in;
	assign sys_clk_src          = s_q.src;
	assign xtal_gain            = s_q.gain;
	assign internal_freq_select = s_q.ifs;
	assign irq                  = s_q.irq;

endmodule

`default_nettype wire

// ### tb/scss_properties.sv
// Port checker for the system clock source select block
`timescale 1ns/100ps
`default_nettype none
module scss_properties (
	// Clock, reset and bus
	input wire logic                hclk,
	input wire logic                hresetn,
	input wire logic                hsel,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic                hready,
	input wire logic                hreadyout,
	input wire logic                hresp,
	// Straps, pins and clock control
	input wire logic [2:0]          clock_mode_select,
	input wire logic                gpio_a_out,
	input wire logic                gpio_a_drive,
	input wire logic                gpio_b_out,
	input wire logic                gpio_b_drive,
	input wire logic                pin_a_o,
	input wire logic                pin_a_oe_n,
	input wire logic                pin_b_o,
	input wire logic                pin_b_oe_n,
	input wire scss_pkg::scss_src_e sys_clk_src,
	input wire logic [1:0]          xtal_gain
);
	logic [1:0] age_q;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Outputs follow the strap only from the second edge after release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			age_q <= 2'h0;
		else if (!age_q[1])
			age_q <= age_q + 2'h1;
	end
	chk_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
	chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
	chk_gain_mode: assert property (age_q[1] |-> xtal_gain == ((clock_mode_select inside
		{[3'h1:3'h3]}) ? clock_mode_select[1:0] : 2'h0)) else $error("gain wrong");
	chk_clkout_div: assert property (age_q[1] && (clock_mode_select inside {3'h4, 3'h6})
		&& $rose(pin_a_o) |-> !pin_a_oe_n ##1 pin_a_o ##1 !pin_a_o ##1 !pin_a_o ##1 pin_a_o)
		else $error("clock out not a quarter");
	chk_pin_a_io: assert property (age_q[1] && (clock_mode_select inside {3'h0, 3'h5, 3'h7})
		|-> pin_a_oe_n == !$past(gpio_a_drive) && pin_a_o == $past(gpio_a_out))
		else $error("pin a not port driven");
	chk_pin_b_io: assert property (age_q[1] && clock_mode_select[2:1] == 2'h3
		|-> pin_b_oe_n == !$past(gpio_b_drive) && pin_b_o == $past(gpio_b_out))
		else $error("pin b not port driven");
	chk_pin_b_free: assert property (age_q[1] && clock_mode_select < 3'h6 |-> pin_b_oe_n)
		else $error("pin b driven");
	chk_src_internal: assert property (age_q[1] && clock_mode_select[2:1] == 2'h3
		|-> sys_clk_src != scss_pkg::SRC_EXT) else $error("internal mode on external");
endmodule
bind scss_top scss_properties scss_properties_i (.hclk, .hresetn, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .clock_mode_select, .gpio_a_out, .gpio_a_drive, .gpio_b_out,
	.gpio_b_drive, .pin_a_o, .pin_a_oe_n, .pin_b_o, .pin_b_oe_n, .sys_clk_src, .xtal_gain);
`default_nettype wire

// ### tb/scss_ext_osc.sv
// External clock source model that can stop like a failed oscillator
`timescale 1ns/100ps
`default_nettype none
module scss_ext_osc #(
	parameter int HALF_NS = 40
) (
	// Control and clock
	input wire logic run,
	output logic     clk
);
	// A dead source holds its level rather than settling anywhere useful
	initial begin
		clk = 1'b0;
		forever begin
			#(HALF_NS);
			if (run)
				clk = ~clk;
		end
	end
endmodule
`default_nettype wire

// ### tb/test_system_clock_source_select.sv
// Register and pin tests for the system clock source select block
`timescale 1ns/100ps
`default_nettype none
module test_system_clock_source_select;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b1;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, t;
	logic [1:0] htrans = 2'h0, xtal_gain;
	logic [2:0] clock_mode_select = 3'h0, internal_freq_select;
	logic two_speed_enable = 1'b0, fail_safe_enable = 1'b0, fast_osc_ready = 1'b0;
	logic slow_osc_ready = 1'b1, gpio_a_out = 1'b0, gpio_a_drive = 1'b1, gpio_b_out = 1'b0;
	logic gpio_b_drive = 1'b1, ext_clk_in, hreadyout, hresp, irq, gpio_a_in, gpio_b_in, p;
	logic pin_a_o, pin_a_oe_n, pin_b_o, pin_b_oe_n;
	wire logic pin_a_i, pin_b_i;
	scss_pkg::scss_src_e sys_clk_src;
	int fails = 0, checks = 0, n;
	// Released pins sit at a pull-up level
	assign pin_a_i = pin_a_oe_n ? 1'b1 : pin_a_o;
	assign pin_b_i = pin_b_oe_n ? 1'b1 : pin_b_o;
	scss_ext_osc scss_ext_osc_i (.run(run), .clk(ext_clk_in));
	scss_top #(.FAIL_CYC(20), .OST_CNT(4)) scss_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.clock_mode_select, .two_speed_enable, .fail_safe_enable, .ext_clk_in, .fast_osc_ready,
		.slow_osc_ready, .pin_a_i, .pin_a_o, .pin_a_oe_n, .pin_b_i, .pin_b_o, .pin_b_oe_n,
		.gpio_a_out, .gpio_a_drive, .gpio_b_out, .gpio_b_drive, .gpio_a_in, .gpio_b_in,
		.sys_clk_src, .xtal_gain, .internal_freq_select, .irq);
	// Clock
	initial begin
		forever #5 hclk = ~hclk;
	end
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	// Straps only change while reset is held
	task automatic rst(input logic [2:0] m, input logic ts, input logic fs);
		hresetn <= 1'b0;
		clock_mode_select <= m;
		two_speed_enable <= ts;
		fail_safe_enable <= fs;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	// One AHB single transfer; waits on hready in both phases
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		t = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(t & mask, exp);
	endtask
	task automatic settle_src(input logic [1:0] exp);
		repeat (3) @(posedge hclk);
		check(32'(sys_clk_src), 32'(exp));
	endtask
	// Cuts a hang short
	initial begin
		#200000;
		fails++;
		report_and_stop;
	end
	initial begin
		// Every mode: gain, source and pin ownership
		for (int m = 0; m < 8; m++) begin
			// Port data differs per mode so a driven pin is told apart from the pull-up
			gpio_a_out <= !m[0];
			gpio_b_out <= m[0];
			rst(3'(m), 1'b0, 1'b0);
			repeat (10) @(posedge hclk);
			rd(scss_pkg::OFS_CLK_STATUS, 32'h7, 32'(m));
			check(32'(xtal_gain), (m inside {[1:3]}) ? 32'(m) : 32'h0);
			check(32'(sys_clk_src), 32'(m > 5));
			check(32'({pin_a_oe_n, pin_b_oe_n}), 32'({m inside {[1:3]}, m < 6}));
			check(32'(gpio_b_in), 32'(m != 6));
			if (!(m inside {4, 6}))
				check(32'(gpio_a_in), 32'(m < 4));
			else begin
				n = 0;
				p = pin_a_o;
				repeat (40) begin
					@(posedge hclk);
					n += int'(pin_a_o & !p);
					p = pin_a_o;
				end
				check(32'(n), 32'ha);
			end
		end
		// Register reset values, access and run-time source choice
		rst(3'h0, 1'b0, 1'b1);
		rd(scss_pkg::OFS_OSC_CONTROL, 32'hffff_fff7, 32'h62);
		xfer(1'b1, scss_pkg::OFS_OSC_CONTROL, 32'hff);
		rd(scss_pkg::OFS_OSC_CONTROL, 32'hffff_fff7, 32'h73);
		settle_src(scss_pkg::SRC_FAST);
		xfer(1'b1, scss_pkg::OFS_OSC_CONTROL, 32'h01);
		settle_src(scss_pkg::SRC_SLOW);
		check(32'(internal_freq_select), 32'h0);
		xfer(1'b1, scss_pkg::OFS_OSC_CONTROL, 32'h60);
		settle_src(scss_pkg::SRC_EXT);
		fast_osc_ready <= 1'b1;
		repeat (6) @(posedge hclk);
		rd(scss_pkg::OFS_OSC_CONTROL, 32'h4, 32'h4);
		rd(scss_pkg::OFS_INT_STATUS, 32'h4, 32'h4);
		xfer(1'b1, 8'h10, 32'hff);
		rd(8'h10, 32'hffff_ffff, 32'h0);
		// Failure with a masked-in interrupt, then a write-one clear
		xfer(1'b1, scss_pkg::OFS_INT_MASK, 32'h1);
		repeat (2) @(posedge hclk);
		check(32'(irq), 32'h0);
		run <= 1'b0;
		repeat (60) @(posedge hclk);
		check(32'(sys_clk_src), 32'(scss_pkg::SRC_FAST));
		rd(scss_pkg::OFS_CLK_STATUS, 32'h20, 32'h20);
		check(32'(irq), 32'h1);
		xfer(1'b1, scss_pkg::OFS_INT_STATUS, 32'h1);
		repeat (2) @(posedge hclk);
		check(32'(irq), 32'h0);
		rd(scss_pkg::OFS_INT_STATUS, 32'h1, 32'h0);
		// Two-speed start-up: internal until the crystal has counted in
		rst(3'h2, 1'b1, 1'b0);
		settle_src(scss_pkg::SRC_FAST);
		run <= 1'b1;
		repeat (100) @(posedge hclk);
		check(32'(sys_clk_src), 32'(scss_pkg::SRC_EXT));
		rd(scss_pkg::OFS_OSC_CONTROL, 32'h8, 32'h8);
		rd(scss_pkg::OFS_INT_STATUS, 32'h2, 32'h2);
		report_and_stop;
	end
endmodule
`default_nettype wire
